// >>> rtl/pst_store.sv
`include "pst_defines.svh"
`default_nettype none
module pst_store #(
  parameter int USER_LINES = `PST_USER_LINES,
  parameter int SVC_LINES  = `PST_SVC_LINES
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        obj_valid_i,
  input  wire logic        obj_write_i,
  input  wire logic [1:0]  obj_space_i,
  input  wire logic [15:0] obj_addr_i,
  input  wire logic [15:0] obj_wdata_i,
  output logic             obj_ready_o,
  output logic             obj_rvalid_o,
  output logic      [15:0] obj_rdata_o,
  input  wire logic        obj_rready_i,
  input  wire logic        run_mode_i,
  input  wire logic        nvm_fault_i
);
  localparam int SW         = `PST_SECTOR_WORDS;
  localparam int USER_WORDS = USER_LINES * SW;
  localparam int SVC_WORDS  = SVC_LINES * SW;
  localparam int AW         = $clog2(USER_WORDS + SVC_WORDS);

  function automatic logic [AW-1:0] word_addr(input logic area, input logic [31:0] offs);
    logic [31:0] base;
    base = area ? 32'(USER_WORDS) : 32'h0000_0000;
    return AW'(base + offs);
  endfunction

  function automatic logic [31:0] area_lines(input logic area);
    return area ? 32'(SVC_LINES) : 32'(USER_LINES);
  endfunction

  pst_pkg::pst_state_t state_q, state_d;
  logic [31:0] cnt_q, cnt_d;
  logic        area_op_q, area_op_d;
  logic        fault_seen_q, fault_seen_d;
  logic        oor_q, oor_d;
  logic        rd_pend_q, rd_pend_d;
  logic [4:0]  rd_idx_q, rd_idx_d;
  logic        op_write_q, op_write_d;
  logic        area_svc_q, area_svc_d;
  logic        prot_user_q, prot_user_d;
  logic        prot_svc_q, prot_svc_d;
  logic        unprot_after_q, unprot_after_d;
  logic        fault_flag_q, fault_flag_d;
  logic [15:0] fault_code_q, fault_code_d;
  logic [15:0] line_q, line_d;
  logic [15:0] dl_q [SW];
  logic [15:0] dl_d [SW];
  logic [15:0] ul_q [SW];
  logic [15:0] ul_d [SW];
  logic [15:0] buf_q [2];
  logic [15:0] buf_d [2];
  logic [1:0]  bcnt_q, bcnt_d;
  logic        rvalid_d, ready_d;

  logic          mem_we, mem_re;
  logic [AW-1:0] mem_waddr, mem_raddr;
  logic [15:0]   mem_wdata, mem_rdata;

  logic          acc, wr_acc, rd_acc, pop;
  logic [15:0]   rd_val;
  logic          bit_in;
  logic [15:0]   sidx;
  logic [15:0]   dl_idx;

  pst_line_mem #(
    .AW (AW),
    .DW (16)
  ) u_mem (
    .core_clk_i (core_clk_i),
    .we_i       (mem_we),
    .waddr_i    (mem_waddr),
    .wdata_i    (mem_wdata),
    .re_i       (mem_re),
    .raddr_i    (mem_raddr),
    .rdata_o    (mem_rdata)
  );

  assign acc    = obj_valid_i && obj_ready_o;
  assign wr_acc = acc && obj_write_i;
  assign rd_acc = acc && !obj_write_i;
  assign pop    = obj_rvalid_o && obj_rready_i;
  assign bit_in = obj_wdata_i[0];
  assign dl_idx = obj_addr_i - `PST_ADDR_DOWNLOAD;

  // Read value of the addressed object; unmapped objects read zero
  always_comb
  begin
    rd_val = 16'h0000;
    sidx   = 16'h0000;
    case (pst_pkg::pst_space_t'(obj_space_i))
      pst_pkg::PST_SPACE_COIL:
      begin
        case (obj_addr_i)
          `PST_ADDR_PROT_USER: rd_val = {15'h0000, prot_user_q};
          `PST_ADDR_PROT_SVC:  rd_val = {15'h0000, prot_svc_q};
          `PST_ADDR_OP_WRITE:  rd_val = {15'h0000, op_write_q};
          `PST_ADDR_AREA_SVC:  rd_val = {15'h0000, area_svc_q};
          `PST_ADDR_FAULT:     rd_val = {15'h0000, fault_flag_q};
          default:             rd_val = 16'h0000;
        endcase
      end
      pst_pkg::PST_SPACE_DISCRETE:
      begin
        if (obj_addr_i == `PST_ADDR_BUSY)
        begin
          rd_val = {15'h0000, state_q != pst_pkg::PST_ST_IDLE};
        end
        else if (obj_addr_i == `PST_ADDR_RUN)
        begin
          rd_val = {15'h0000, run_mode_i};
        end
      end
      pst_pkg::PST_SPACE_HOLDING:
      begin
        sidx = obj_addr_i - `PST_ADDR_DOWNLOAD;
        if (obj_addr_i == `PST_ADDR_LINE_INDEX)
        begin
          rd_val = line_q;
        end
        else if (sidx < 16'(SW))
        begin
          rd_val = dl_q[sidx[4:0]];
        end
      end
      default:
      begin
        sidx = obj_addr_i - `PST_ADDR_UPLOAD;
        if (obj_addr_i == `PST_ADDR_FAULT)
        begin
          rd_val = fault_code_q;
        end
        else if (sidx < 16'(SW))
        begin
          rd_val = ul_q[sidx[4:0]];
        end
      end
    endcase
  end

  // Two-entry answer buffer; the host stalls it with obj_rready_i
  always_comb
  begin
    buf_d  = buf_q;
    bcnt_d = bcnt_q;
    if (pop)
    begin
      buf_d[0] = buf_q[1];
      bcnt_d   = bcnt_d - 2'd1;
    end
    if (rd_acc)
    begin
      buf_d[bcnt_d[0]] = rd_val;
      bcnt_d           = bcnt_d + 2'd1;
    end
    rvalid_d = bcnt_d != 2'd0;
    ready_d  = bcnt_d != 2'd2;
  end

  // Register writes and the operation sequencer
  always_comb
  begin
    state_d        = state_q;
    cnt_d          = cnt_q;
    area_op_d      = area_op_q;
    fault_seen_d   = fault_seen_q;
    oor_d          = oor_q;
    rd_pend_d      = 1'b0;
    rd_idx_d       = rd_idx_q;
    op_write_d     = op_write_q;
    area_svc_d     = area_svc_q;
    prot_user_d    = prot_user_q;
    prot_svc_d     = prot_svc_q;
    unprot_after_d = unprot_after_q;
    fault_flag_d   = fault_flag_q;
    fault_code_d   = fault_code_q;
    line_d         = line_q;
    dl_d           = dl_q;
    ul_d           = ul_q;
    mem_we         = 1'b0;
    mem_re         = 1'b0;
    mem_waddr      = '0;
    mem_raddr      = '0;
    mem_wdata      = 16'h0000;

    if (wr_acc && pst_pkg::pst_space_t'(obj_space_i) == pst_pkg::PST_SPACE_COIL)
    begin
      case (obj_addr_i)
        `PST_ADDR_OP_WRITE: op_write_d = bit_in;
        `PST_ADDR_AREA_SVC: area_svc_d = bit_in;
        `PST_ADDR_FAULT:    fault_flag_d = fault_flag_q && bit_in;
        default:            ;
      endcase
      if (!bit_in && obj_addr_i == `PST_ADDR_PROT_USER)
      begin
        prot_user_d = 1'b0;
      end
      if (!bit_in && obj_addr_i == `PST_ADDR_PROT_SVC)
      begin
        prot_svc_d = 1'b0;
      end
    end
    if (wr_acc && pst_pkg::pst_space_t'(obj_space_i) == pst_pkg::PST_SPACE_HOLDING)
    begin
      if (obj_addr_i == `PST_ADDR_LINE_INDEX)
      begin
        line_d = obj_wdata_i;
      end
      else if (dl_idx < 16'(SW))
      begin
        dl_d[dl_idx[4:0]] = obj_wdata_i;
      end
    end

    case (state_q)
      pst_pkg::PST_ST_IDLE:
      begin
        cnt_d        = 32'h0000_0000;
        fault_seen_d = 1'b0;
        if (wr_acc && bit_in && !run_mode_i
            && pst_pkg::pst_space_t'(obj_space_i) == pst_pkg::PST_SPACE_COIL)
        begin
          case (obj_addr_i)
            `PST_ADDR_ERASE_USER, `PST_ADDR_ERASE_SVC:
            begin
              area_op_d      = obj_addr_i == `PST_ADDR_ERASE_SVC;
              unprot_after_d = 1'b0;
              state_d        = pst_pkg::PST_ST_ERASE;
            end
            `PST_ADDR_PROT_USER, `PST_ADDR_PROT_SVC:
            begin
              area_op_d = obj_addr_i == `PST_ADDR_PROT_SVC;
              if (!(obj_addr_i == `PST_ADDR_PROT_SVC ? prot_svc_q : prot_user_q))
              begin
                unprot_after_d = 1'b1;
                state_d        = pst_pkg::PST_ST_ERASE;
              end
            end
            `PST_ADDR_TRIGGER:
            begin
              area_op_d = area_svc_q;
              oor_d     = 32'(line_q) >= area_lines(area_svc_q);
              if (op_write_q)
              begin
                state_d = pst_pkg::PST_ST_WRITE;
              end
              else if (!(area_svc_q ? prot_svc_q : prot_user_q))
              begin
                fault_flag_d = 1'b1;
                fault_code_d = area_svc_q ? `PST_CODE_PROT_SVC : `PST_CODE_PROT_USER;
              end
              else
              begin
                state_d = pst_pkg::PST_ST_READ;
              end
            end
            default: ;
          endcase
        end
      end
      pst_pkg::PST_ST_ERASE:
      begin
        mem_we       = 1'b1;
        mem_waddr    = word_addr(area_op_q, cnt_q);
        fault_seen_d = fault_seen_q || nvm_fault_i;
        cnt_d        = cnt_q + 32'd1;
        if (cnt_q == area_lines(area_op_q) * 32'(SW) - 32'd1)
        begin
          state_d = pst_pkg::PST_ST_IDLE;
          if (fault_seen_d)
          begin
            fault_flag_d = 1'b1;
            fault_code_d = area_op_q ? `PST_CODE_ERASE_SVC : `PST_CODE_ERASE_USER;
          end
          else if (unprot_after_q)
          begin
            if (area_op_q)
            begin
              prot_svc_d = 1'b1;
            end
            else
            begin
              prot_user_d = 1'b1;
            end
          end
        end
      end
      pst_pkg::PST_ST_WRITE:
      begin
        mem_we       = !oor_q;
        mem_waddr    = word_addr(area_op_q, 32'(line_q) * 32'(SW) + cnt_q);
        mem_wdata    = dl_q[cnt_q[4:0]];
        fault_seen_d = fault_seen_q || nvm_fault_i || oor_q;
        cnt_d        = cnt_q + 32'd1;
        if (cnt_q == 32'(SW - 1))
        begin
          state_d = pst_pkg::PST_ST_IDLE;
          if (fault_seen_d)
          begin
            fault_flag_d = 1'b1;
            fault_code_d = area_op_q ? `PST_CODE_WRITE_SVC : `PST_CODE_WRITE_USER;
          end
        end
      end
      pst_pkg::PST_ST_READ:
      begin
        if (rd_pend_q)
        begin
          ul_d[rd_idx_q] = oor_q ? 16'h0000 : mem_rdata;
        end
        if (cnt_q < 32'(SW))
        begin
          mem_re    = 1'b1;
          mem_raddr = word_addr(area_op_q, 32'(line_q) * 32'(SW) + cnt_q);
          rd_pend_d = 1'b1;
          rd_idx_d  = cnt_q[4:0];
          cnt_d     = cnt_q + 32'd1;
        end
        else if (!rd_pend_q)
        begin
          state_d = pst_pkg::PST_ST_IDLE;
        end
      end
      default: state_d = pst_pkg::PST_ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      state_q        <= pst_pkg::PST_ST_IDLE;
      cnt_q          <= 32'h0000_0000;
      area_op_q      <= 1'b0;
      fault_seen_q   <= 1'b0;
      oor_q          <= 1'b0;
      rd_pend_q      <= 1'b0;
      rd_idx_q       <= 5'h00;
      op_write_q     <= 1'b0;
      area_svc_q     <= 1'b0;
      prot_user_q    <= `PST_PROT_RESET;
      prot_svc_q     <= `PST_PROT_RESET;
      unprot_after_q <= 1'b0;
      fault_flag_q   <= 1'b0;
      fault_code_q   <= `PST_CODE_NONE;
      line_q         <= 16'h0000;
      dl_q           <= '{default: 16'h0000};
      ul_q           <= '{default: 16'h0000};
      buf_q          <= '{default: 16'h0000};
      bcnt_q         <= 2'd0;
      obj_rvalid_o   <= 1'b0;
      obj_ready_o    <= 1'b1;
    end
    else
    begin
      state_q        <= state_d;
      cnt_q          <= cnt_d;
      area_op_q      <= area_op_d;
      fault_seen_q   <= fault_seen_d;
      oor_q          <= oor_d;
      rd_pend_q      <= rd_pend_d;
      rd_idx_q       <= rd_idx_d;
      op_write_q     <= op_write_d;
      area_svc_q     <= area_svc_d;
      prot_user_q    <= prot_user_d;
      prot_svc_q     <= prot_svc_d;
      unprot_after_q <= unprot_after_d;
      fault_flag_q   <= fault_flag_d;
      fault_code_q   <= fault_code_d;
      line_q         <= line_d;
      dl_q           <= dl_d;
      ul_q           <= ul_d;
      buf_q          <= buf_d;
      bcnt_q         <= bcnt_d;
      obj_rvalid_o   <= rvalid_d;
      obj_ready_o    <= ready_d;
    end
  end

  assign obj_rdata_o = buf_q[0];
endmodule
`default_nettype wire

// >>> rtl/pst_defines.svh
// Function
// - Separate read protection per area; protected area delivers no program line.
// - Erase coils clear the user area or the service area.
// - Busy input stays set during erase; host waits for it to clear.
// - Operation-type coil: set selects line write, clear selects line read.
// - Area-select coil: clear targets user area, set targets service area.
// - Line index register, zero based, used by reads and writes.
// - Trigger coil starts one operation using index, type and area.
// - Read returns the line in the upload sector; host stops at end.
// - Operand types are stored as one-byte codes.
// - Failed operation sets the fault flag coil and a 16-bit fault code.
// - Codes 0001h/0002h report user/service read-protection faults.
// - Codes 0003h/0004h for erase faults, 0005h/0006h for write faults.
// - Run/stop state is a discrete input; memory changes refused in run.
// - User protection coil reads set when unprotected; setting it while protected erases.
`ifndef PST_DEFINES_SVH
`define PST_DEFINES_SVH

`define PST_ADDR_BUSY        16'hF000
`define PST_ADDR_TRIGGER     16'hF000
`define PST_ADDR_RUN         16'hF001
`define PST_ADDR_PROT_USER   16'hF001
`define PST_ADDR_PROT_SVC    16'hF002
`define PST_ADDR_ERASE_USER  16'hF003
`define PST_ADDR_ERASE_SVC   16'hF004
`define PST_ADDR_OP_WRITE    16'hF005
`define PST_ADDR_AREA_SVC    16'hF006
`define PST_ADDR_LINE_INDEX  16'hF100
`define PST_ADDR_UPLOAD      16'hF200
`define PST_ADDR_DOWNLOAD    16'hF300
`define PST_ADDR_FAULT       16'hE002

`define PST_SECTOR_WORDS     21
`define PST_USER_LINES       59754
`define PST_SVC_LINES        1928
`define PST_PROT_RESET       1'b1

`define PST_CODE_NONE        16'h0000
`define PST_CODE_PROT_USER   16'h0001
`define PST_CODE_PROT_SVC    16'h0002
`define PST_CODE_ERASE_USER  16'h0003
`define PST_CODE_ERASE_SVC   16'h0004
`define PST_CODE_WRITE_USER  16'h0005
`define PST_CODE_WRITE_SVC   16'h0006

`define PST_OPND_K 8'h4B
`define PST_OPND_H 8'h48
`define PST_OPND_F 8'h46
`define PST_OPND_X 8'h58
`define PST_OPND_Y 8'h59
`define PST_OPND_M 8'h4D
`define PST_OPND_T 8'h54
`define PST_OPND_C 8'h43
`define PST_OPND_A 8'h41
`define PST_OPND_B 8'h42
`define PST_OPND_D 8'h12
`define PST_OPND_P 8'h50
`define PST_OPND_I 8'h49

`endif

// >>> rtl/pst_pkg.sv
`default_nettype none
package pst_pkg;
  typedef enum logic [1:0] {
    PST_SPACE_COIL,
    PST_SPACE_DISCRETE,
    PST_SPACE_HOLDING,
    PST_SPACE_INPUT
  } pst_space_t;

  typedef enum logic [1:0] {
    PST_ST_IDLE,
    PST_ST_ERASE,
    PST_ST_WRITE,
    PST_ST_READ
  } pst_state_t;
endpackage
`default_nettype wire

// >>> rtl/pst_line_mem.sv
`default_nettype none
module pst_line_mem #(
  parameter int AW = 21,
  parameter int DW = 16
) (
  input  wire logic          core_clk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic          re_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [DW-1:0] rdata_o
);
  logic [DW-1:0] mem_q [2**AW];

  always_ff @(posedge core_clk_i)
  begin
    if (we_i)
    begin
      mem_q[waddr_i] <= wdata_i;
    end
    if (re_i)
    begin
      rdata_o <= mem_q[raddr_i];
    end
  end
endmodule
`default_nettype wire

// >>> testbench/pst_store_props.sv
`default_nettype none
module pst_store_props (
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  input wire logic        obj_valid_i,
  input wire logic        obj_write_i,
  input wire logic [1:0]  obj_space_i,
  input wire logic [15:0] obj_addr_i,
  input wire logic        obj_ready_o,
  input wire logic        obj_rvalid_o,
  input wire logic [15:0] obj_rdata_o,
  input wire logic        obj_rready_i,
  input wire logic        run_mode_i
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  // Read taken while the answer buffer is empty
  logic rd_acc;
  assign rd_acc = obj_valid_i && obj_ready_o && !obj_write_i && !obj_rvalid_o;

  a_reset_idle: assert property (disable iff (1'b0)
    rst_i |=> obj_ready_o && !obj_rvalid_o && obj_rdata_o == 16'h0000)
    else $error("outputs not idle after reset");
  a_answer_holds: assert property (
    obj_rvalid_o && !obj_rready_i |=> obj_rvalid_o && $stable(obj_rdata_o))
    else $error("answer dropped or changed before it was taken");
  a_read_answers: assert property (rd_acc |=> obj_rvalid_o)
    else $error("read gave no answer one cycle later");
  a_write_silent: assert property (
    obj_valid_i && obj_ready_o && obj_write_i && !obj_rvalid_o |=> !obj_rvalid_o)
    else $error("write produced an answer");
  a_full_stall: assert property (!obj_ready_o |-> obj_rvalid_o)
    else $error("ready low with empty answer buffer");
  a_ready_back: assert property (!obj_ready_o && obj_rready_i |=> obj_ready_o)
    else $error("ready stayed low after an answer was taken");
  a_unmapped_zero: assert property (
    rd_acc && obj_space_i == 2'd0 && obj_addr_i == 16'h1234 |=> obj_rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  a_run_state: assert property (
    rd_acc && obj_space_i == 2'd1 && obj_addr_i == 16'hF001
    |=> obj_rdata_o[0] == $past(run_mode_i))
    else $error("run state read back wrong");
endmodule

bind pst_store pst_store_props i_pst_store_props (.core_clk_i, .rst_i, .obj_valid_i,
  .obj_write_i, .obj_space_i, .obj_addr_i, .obj_ready_o, .obj_rvalid_o, .obj_rdata_o,
  .obj_rready_i, .run_mode_i);
`default_nettype wire

// >>> testbench/pst_host_model.sv
`default_nettype none
module pst_host_model (
  input  wire logic core_clk_i,
  input  wire logic stall_i,
  output logic      rready_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Takes answers at a random pace, none while stalled
  initial
  begin
    rready_o = 1'b0;
    forever
    begin
      @(negedge core_clk_i);
      rready_o <= !stall_i && ($urandom % 4 != 0);
    end
  end
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk_i  = 1'b0;
  logic        rst_i       = 1'b1;
  logic        obj_valid_i = 1'b0;
  logic        obj_write_i = 1'b0;
  logic [1:0]  obj_space_i = 2'd0;
  logic [15:0] obj_addr_i  = 16'h0000;
  logic [15:0] obj_wdata_i = 16'h0000;
  logic        obj_ready_o;
  logic        obj_rvalid_o;
  logic [15:0] obj_rdata_o;
  logic        obj_rready_i;
  logic        run_mode_i  = 1'b0;
  logic        nvm_fault_i = 1'b0;
  logic        stall       = 1'b0;
  logic [16:0] exp_q [$];
  logic [15:0] last_rd;
  logic [15:0] dat [2][21];
  int          err_count   = 0;
  int          tests_run   = 0;
  int          cyc         = 0;

  pst_store #(.USER_LINES(4), .SVC_LINES(2)) i_pst_store (.core_clk_i, .rst_i, .obj_valid_i,
    .obj_write_i, .obj_space_i, .obj_addr_i, .obj_wdata_i, .obj_ready_o, .obj_rvalid_o,
    .obj_rdata_o, .obj_rready_i, .run_mode_i, .nvm_fault_i);
  pst_host_model i_pst_host_model (.core_clk_i, .stall_i(stall), .rready_o(obj_rready_i));

  initial forever #20 core_clk_i = ~core_clk_i;

  task automatic wrap_up;
    $display("Mismatches %0d, comparisons %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic req(input logic w, input logic [1:0] s, input logic [15:0] a,
                     input logic [15:0] d);
    int n;
    n = 0;
    @(negedge core_clk_i);
    obj_valid_i = 1'b1;
    obj_write_i = w;
    obj_space_i = s;
    obj_addr_i  = a;
    obj_wdata_i = d;
    while (obj_ready_o !== 1'b1 && n < 200)
    begin
      @(negedge core_clk_i);
      n++;
    end
    if (obj_ready_o !== 1'b1) cmp(16'h0000, 16'h0001);
    @(negedge core_clk_i);
    obj_valid_i = 1'b0;
  endtask

  task automatic rd(input logic [1:0] s, input logic [15:0] a, input logic [15:0] e);
    exp_q.push_back({1'b0, e});
    req(1'b0, s, a, 16'h0000);
  endtask

  task automatic drain;
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 200)
    begin
      @(negedge core_clk_i);
      n++;
    end
    if (exp_q.size() != 0) cmp(16'(exp_q.size()), 16'h0000);
  endtask

  // Busy state lands in last_rd, not compared by the monitor
  task automatic poll;
    exp_q.push_back(17'h10000);
    req(1'b0, 2'd1, 16'hF000, 16'h0000);
    drain();
  endtask

  task automatic go(input logic [15:0] a, input logic [15:0] b);
    int n;
    n = 0;
    req(1'b1, 2'd0, a, 16'h0001);
    poll();
    cmp(last_rd, b);
    while (last_rd !== 16'h0000 && n < 300)
    begin
      poll();
      n++;
    end
    cmp(last_rd, 16'h0000);
  endtask

  task automatic setup(input logic w, input logic [15:0] a, input logic [15:0] n);
    req(1'b1, 2'd0, 16'hF005, {15'h0, w});
    req(1'b1, 2'd0, 16'hF006, a);
    req(1'b1, 2'd2, 16'hF100, n);
  endtask

  task automatic line_wr(input logic [15:0] a, input logic [15:0] n);
    setup(1'b1, a, n);
    for (int i = 0; i < 21; i++) req(1'b1, 2'd2, 16'hF300 + 16'(i), dat[a][i]);
    go(16'hF000, 16'h0001);
  endtask

  task automatic line_rd(input logic [15:0] a, input logic [15:0] n, input logic z);
    setup(1'b0, a, n);
    go(16'hF000, 16'h0001);
    for (int i = 0; i < 21; i++) rd(2'd3, 16'hF200 + 16'(i), z ? 16'h0000 : dat[a][i]);
  endtask

  task automatic fault(input logic [15:0] code);
    rd(2'd0, 16'hE002, 16'h0001);
    rd(2'd3, 16'hE002, code);
    req(1'b1, 2'd0, 16'hE002, 16'h0000);
    rd(2'd0, 16'hE002, 16'h0000);
  endtask

  always @(posedge core_clk_i)
  begin
    if (obj_rvalid_o === 1'b1 && obj_rready_i === 1'b1)
    begin
      last_rd = obj_rdata_o;
      if (exp_q.size() == 0)
        cmp(16'hDEAD, 16'hBEEF);
      else if (exp_q[0][16] === 1'b0)
        cmp(obj_rdata_o, exp_q[0][15:0]);
      if (exp_q.size() != 0)
        void'(exp_q.pop_front());
    end
  end

  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      err_count++;
      wrap_up();
    end
  end

  initial
  begin
    void'($urandom(32'he409));
    for (int a = 0; a < 2; a++) for (int i = 0; i < 21; i++) dat[a][i] = 16'($urandom);
    dat[0][1] = 16'h4B58;
    repeat (5) @(negedge core_clk_i);
    rst_i = 1'b0;
    rd(2'd0, 16'hF001, 16'h0001);
    rd(2'd0, 16'hF002, 16'h0001);
    rd(2'd0, 16'hF005, 16'h0000);
    rd(2'd2, 16'hF100, 16'h0000);
    rd(2'd3, 16'hE002, 16'h0000);
    drain();
    // Two answers held back fill the buffer
    stall <= 1'b1;
    rd(2'd0, 16'h1234, 16'h0000);
    rd(2'd1, 16'hF001, 16'h0000);
    @(negedge core_clk_i);
    cmp(16'(obj_ready_o), 16'h0000);
    stall <= 1'b0;
    drain();
    go(16'hF003, 16'h0001);
    line_wr(16'h0000, 16'h0001);
    run_mode_i = 1'b1;
    rd(2'd1, 16'hF001, 16'h0001);
    go(16'hF003, 16'h0000);
    run_mode_i = 1'b0;
    line_rd(16'h0000, 16'h0001, 1'b0);
    go(16'hF004, 16'h0001);
    line_wr(16'h0001, 16'h0000);
    line_rd(16'h0001, 16'h0000, 1'b0);
    line_rd(16'h0000, 16'h0001, 1'b0);
    for (int a = 0; a < 2; a++)
    begin
      req(1'b1, 2'd0, 16'hF001 + 16'(a), 16'h0000);
      rd(2'd0, 16'hF001 + 16'(a), 16'h0000);
      setup(1'b0, 16'(a), 16'h0000);
      go(16'hF000, 16'h0000);
      fault(16'h0001 + 16'(a));
      go(16'hF001 + 16'(a), 16'h0001);
      rd(2'd0, 16'hF001 + 16'(a), 16'h0001);
      line_rd(16'(a), 16'h0001 - 16'(a), 1'b1);
      nvm_fault_i = 1'b1;
      go(16'hF003 + 16'(a), 16'h0001);
      nvm_fault_i = 1'b0;
      fault(16'h0003 + 16'(a));
      line_wr(16'(a), 16'h0004 >> a);
      fault(16'h0005 + 16'(a));
    end
    drain();
    wrap_up();
  end
endmodule
`default_nettype wire
